// ===== edts_dma_stats.sv
`timescale 1ns/1ns
`default_nettype none
module edts_dma_stats (
  // clock and reset
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  // apb slave
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [31:0]               paddr,
  input  wire logic [31:0]               pwdata,
  input  wire logic [3:0]                pstrb,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  // transmit status from the mac core
  input  wire logic                      tx_status_valid,
  input  wire edts_pkg::edts_tx_status_t tx_status,
  // ahb master side of the dma
  input  wire logic                      ahb_busy,
  input  wire logic                      tx_desc_phase,
  input  wire logic                      rx_desc_phase,
  output logic      [2:0]                tx_hburst,
  output logic      [2:0]                rx_hburst,
  output logic                           dma_reset_active,
  output logic                           loop_back,
  // receive fifo feed
  input  wire edts_pkg::edts_word_t      tx_fifo_word,
  output logic                           tx_fifo_pop,
  input  wire edts_pkg::edts_word_t      mac_rx_word,
  output edts_pkg::edts_word_t           rx_fifo_word
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [edts_pkg::CNT_NUM-1:0][31:0] cnt;
    logic [7:0]                         ctrl;
    logic [31:0]                        rdata;
    logic                               addr_err;
    edts_pkg::edts_word_t               rx_out;
    logic [2:0]                         tx_hb;
    logic [2:0]                         rx_hb;
  } edts_regs_t;

  edts_regs_t r;
  edts_regs_t next_r;

  logic [edts_pkg::CNT_NUM-1:0] inc;
  logic                         setup;
  logic                         access;
  logic                         wr_ctrl;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // index CNT_NUM means the control register, above it unmapped
  function automatic logic [4:0] addr_index(input logic [31:0] a);
    logic [4:0] idx;
    idx = 5'h1F;
    if (a == edts_pkg::ADDR_STS_CNTL) begin
      idx = 5'(edts_pkg::CNT_NUM);
    end
    for (int i = 0; i < edts_pkg::CNT_NUM; i++) begin
      if (a == edts_pkg::CNT_ADDR[i]) begin
        idx = 5'(i);
      end
    end
    return idx;
  endfunction

  function automatic logic [2:0] burst_code(input logic [1:0] f, input logic desc);
    logic [2:0] hb;
    hb = edts_pkg::HBURST_SINGLE;
    case (edts_pkg::edts_burst_t'(f))
      edts_pkg::BURST_INCR16: hb = edts_pkg::HBURST_INCR16;
      edts_pkg::BURST_INCR8:  hb = edts_pkg::HBURST_INCR8;
      edts_pkg::BURST_INCR4:  hb = edts_pkg::HBURST_INCR4;
      edts_pkg::BURST_SINGLE: hb = edts_pkg::HBURST_SINGLE;
      default:                hb = edts_pkg::HBURST_SINGLE;
    endcase
    // descriptor reads keep their own burst, whatever the limit says
    return desc ? edts_pkg::HBURST_DESC : hb;
  endfunction

  function automatic logic [31:0] sts_word(input logic [7:0] c);
    return {edts_pkg::FIXED_HIGH, edts_pkg::REVISION_ARB, c};
  endfunction

  // ------------------------------------------------------------
  // submodules
  // ------------------------------------------------------------
  edts_tx_decode u_decode (
    .status (tx_status),
    .inc    (inc)
  );

  edts_soft_reset u_dma_soft_reset (
    .pclk         (pclk),
    .presetn      (presetn),
    .dma_soft_reset_bit   (r.ctrl[edts_pkg::DMA_SOFT_RESET_BIT]),
    .ahb_busy     (ahb_busy),
    .reset_active (dma_reset_active)
  );

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  assign setup   = psel && !penable;
  assign access  = psel && penable;
  assign wr_ctrl = access && pwrite && pstrb[0] && (paddr == edts_pkg::ADDR_STS_CNTL);

  always_comb begin
    logic [4:0] idx;
    idx    = addr_index(paddr);
    next_r = r;

    // read data is fetched in the setup phase so prdata comes from a flop
    if (setup) begin
      next_r.addr_err = (idx > 5'(edts_pkg::CNT_NUM));
      if (idx == 5'(edts_pkg::CNT_NUM)) begin
        next_r.rdata = sts_word(r.ctrl);
      end else if (idx < 5'(edts_pkg::CNT_NUM)) begin
        next_r.rdata = r.cnt[idx];
      end else begin
        next_r.rdata = '0;
      end
    end

    // only bits 7:4, 1 and 0 of the low byte are writable, the rest reads back fixed
    if (wr_ctrl) begin
      next_r.ctrl[7:4]                    = pwdata[7:4];
      next_r.ctrl[edts_pkg::DMA_LOOP_BACK_BIT]    = pwdata[edts_pkg::DMA_LOOP_BACK_BIT];
      next_r.ctrl[edts_pkg::DMA_SOFT_RESET_BIT]   = pwdata[edts_pkg::DMA_SOFT_RESET_BIT];
    end

    if (dma_reset_active) begin
      next_r.cnt = '0;
    end else if (tx_status_valid) begin
      for (int i = 0; i < edts_pkg::CNT_NUM; i++) begin
        next_r.cnt[i] = r.cnt[i] + {31'h0, inc[i]};
      end
    end

    next_r.tx_hb = burst_code(r.ctrl[edts_pkg::TX_BURST_LSB +: 2], tx_desc_phase);
    next_r.rx_hb = burst_code(r.ctrl[edts_pkg::RX_BURST_LSB +: 2], rx_desc_phase);

    if (dma_reset_active) begin
      next_r.rx_out = '0;
    end else if (r.ctrl[edts_pkg::DMA_LOOP_BACK_BIT]) begin
      next_r.rx_out = tx_fifo_word;
    end else begin
      next_r.rx_out = mac_rx_word;
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r          <= '0;
      r.ctrl     <= edts_pkg::CTRL_RESET;
      r.tx_hb    <= edts_pkg::HBURST_INCR16;
      r.rx_hb    <= edts_pkg::HBURST_INCR16;
    end else begin
      r <= next_r;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign prdata       = r.rdata;
  assign pready       = 1'b1;
  assign pslverr      = access && r.addr_err;
  assign tx_hburst    = r.tx_hb;
  assign rx_hburst    = r.rx_hb;
  assign loop_back    = r.ctrl[edts_pkg::DMA_LOOP_BACK_BIT];
  // the receive path is always ready, so a valid word is taken at once
  assign tx_fifo_pop  = loop_back && !dma_reset_active && tx_fifo_word.valid;
  assign rx_fifo_word = r.rx_out;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_counting;
    tx_status_valid && !dma_reset_active;
  endsequence

  sequence s_still_running;
    ##1 !dma_reset_active;
  endsequence

  chk_len64_bumps: assert property (
    (s_counting and (tx_status.frame_len == edts_pkg::LEN_64) && !tx_status.retry)
      ##0 s_still_running |-> r.cnt[0] == $past(r.cnt[0]) + 32'h1)
    else $error("64 byte bin did not step");

  chk_bins_skip_retry: assert property (
    (s_counting and tx_status.retry) ##0 s_still_running
      |-> r.cnt[5:0] == $past(r.cnt[5:0]))
    else $error("length bin moved on a retry");

  chk_bcast_good_only: assert property (
    (s_counting and tx_status.broadcast && (tx_status.aborted || tx_status.retry))
      ##0 s_still_running |-> r.cnt[edts_pkg::CNT_BCAST] == $past(r.cnt[edts_pkg::CNT_BCAST]))
    else $error("broadcast counter took a bad frame");

  chk_single_coll: assert property (
    (s_counting and tx_status.retry && (tx_status.coll_count == 4'h1)) ##0 s_still_running
      |-> r.cnt[edts_pkg::CNT_SINGLE] == $past(r.cnt[edts_pkg::CNT_SINGLE]) + 32'h1)
    else $error("single collision counter did not step");

  // 32-bit sum wraps, so the same check also covers the step from all ones to zero
  chk_counter_wrap: assert property (
    (s_counting and inc[edts_pkg::CNT_UNICAST]) ##0 s_still_running
      |-> r.cnt[edts_pkg::CNT_UNICAST] == $past(r.cnt[edts_pkg::CNT_UNICAST]) + 32'h1)
    else $error("counter did not step by one modulo its width");

  chk_sts_fixed: assert property (
    (access && !pwrite && (paddr == edts_pkg::ADDR_STS_CNTL))
      |-> prdata[31:16] == edts_pkg::FIXED_HIGH)
    else $error("fixed capability fields read wrong");

  chk_desc_burst: assert property (
    tx_desc_phase |=> tx_hburst == edts_pkg::HBURST_DESC)
    else $error("descriptor fetch burst followed the limit field");

  chk_loopback_path: assert property (
    (loop_back && !dma_reset_active) ##1 !dma_reset_active
      |-> rx_fifo_word == $past(tx_fifo_word))
    else $error("loopback did not feed the receive fifo");

  chk_dma_soft_reset_release: assert property (
    (wr_ctrl && !pwdata[edts_pkg::DMA_SOFT_RESET_BIT]) |=> ##1 !dma_reset_active)
    else $error("clearing soft reset did not release the logic");

  chk_reset_value: assert property (
    $rose(presetn) |-> (r.ctrl == edts_pkg::CTRL_RESET) && dma_reset_active)
    else $error("control byte wrong after hardware reset");

endmodule
`default_nettype wire

// ===== edts_pkg.sv
// Functional notes
// - count sent frames of exactly 64 bytes, good and bad, never retries.
// - separate length bins 65-127 to 1024-max, good and bad, no retries.
// - unicast, multicast and broadcast counters take good frames only, no retries.
// - underrun in the status word bumps the fifo-error abort counter.
// - frame abort or heartbeat failure bumps the bad-frame counter.
// - collision count of one with packet retry bumps single-collision counter.
// - collision count above one with packet retry bumps multi-collision counter.
// - deferral bumps deferred counter; excessive deferral bumps its own counter.
// - late collision in the status word bumps the late-collision counter.
// - frame aborted in the status word bumps the aborted-frame counter.
// - no carrier or carrier lost bumps the no-carrier counter.
// - every register is 32 bits wide.
// - transmit and receive fifo size fields read code 4, sixteen words.
// - data width and channel status fields read 2'b10 both ways.
// - a read-only 8-bit revision field names the dma version.
// - 2-bit burst limit per direction: incr16, incr8, incr4, single.
// - descriptor fetches ignore the burst limit fields.
// - loopback moves transmit fifo data into the receive fifo.
// - soft reset bit at one holds dma and mac logic in reset.
// - soft reset comes up set; software clears it once clocks settle.
// - soft reset waits for the last queued ahb master transfer.
// - counters update once per transmit status report.
package edts_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam int          CNT_NUM         = 18;
  localparam logic [31:0] ADDR_STS_CNTL   = 32'h3000_3000;
  // counter index 0 .. 17, listed from index 17 down to 0
  localparam logic [CNT_NUM-1:0][31:0] CNT_ADDR = {
    32'h3000_3754, 32'h3000_3750, 32'h3000_374C, 32'h3000_3748,
    32'h3000_3744, 32'h3000_3740, 32'h3000_373C, 32'h3000_3738,
    32'h3000_3734, 32'h3000_3730, 32'h3000_272C, 32'h3000_3728,
    32'h3000_3724, 32'h3000_3720, 32'h3000_371C, 32'h3000_3718,
    32'h3000_3714, 32'h3000_3710};
  localparam int CNT_LEN64   = 0;
  localparam int CNT_UNICAST = 6;
  localparam int CNT_BCAST   = 8;
  localparam int CNT_SINGLE  = 11;

  // ------------------------------------------------------------
  // status and control layout
  // ------------------------------------------------------------
  localparam logic [3:0] FIFO_SIZE_CODE  = 4'h4;
  localparam logic [1:0] DATA_WIDTH_CODE = 2'h2;
  localparam logic [1:0] CHAN_STAT_CODE  = 2'h2;
  localparam logic [7:0] REVISION_ARB    = 8'h5A; // arbitrary value
  localparam logic [7:0] CTRL_RESET      = 8'h01;
  localparam int         DMA_SOFT_RESET_BIT      = 0;
  localparam int         DMA_LOOP_BACK_BIT       = 1;
  localparam int         RX_BURST_LSB    = 4;
  localparam int         TX_BURST_LSB    = 6;
  localparam logic [15:0] FIXED_HIGH     = {FIFO_SIZE_CODE, DATA_WIDTH_CODE, CHAN_STAT_CODE,
                                            FIFO_SIZE_CODE, DATA_WIDTH_CODE, CHAN_STAT_CODE};

  typedef enum logic [1:0] {
    BURST_INCR16 = 2'h0,
    BURST_INCR8  = 2'h1,
    BURST_INCR4  = 2'h2,
    BURST_SINGLE = 2'h3
  } edts_burst_t;

  localparam logic [2:0] HBURST_SINGLE = 3'h0;
  localparam logic [2:0] HBURST_INCR4  = 3'h3;
  localparam logic [2:0] HBURST_INCR8  = 3'h5;
  localparam logic [2:0] HBURST_INCR16 = 3'h7;
  localparam logic [2:0] HBURST_DESC   = HBURST_INCR4;

  // ------------------------------------------------------------
  // frame length bin edges
  // ------------------------------------------------------------
  localparam logic [13:0] LEN_64   = 14'h0040;
  localparam logic [13:0] LEN_127  = 14'h007F;
  localparam logic [13:0] LEN_255  = 14'h00FF;
  localparam logic [13:0] LEN_511  = 14'h01FF;
  localparam logic [13:0] LEN_1023 = 14'h03FF;

  typedef struct packed {
    logic [13:0] frame_len;
    logic        retry;
    logic [3:0]  coll_count;
    logic        aborted;
    logic        heartbeat_fail;
    logic        underrun;
    logic        deferred;
    logic        excess_deferral;
    logic        late_coll;
    logic        no_carrier;
    logic        loss_carrier;
    logic        multicast;
    logic        broadcast;
  } edts_tx_status_t;

  typedef struct packed {
    logic [31:0] data;
    logic        valid;
  } edts_word_t;

endpackage

// ===== edts_tx_decode.sv
`timescale 1ns/1ns
`default_nettype none
module edts_tx_decode (
  // per-frame transmit status
  input  wire edts_pkg::edts_tx_status_t     status,
  // one bit per counter
  output logic [edts_pkg::CNT_NUM-1:0]       inc
);
  logic no_retry;
  logic good;
  logic [13:0] len;

  always_comb begin
    len      = status.frame_len;
    no_retry = !status.retry;
    good     = !status.aborted && !status.retry;
    inc      = '0;
    inc[0]   = no_retry && (len == edts_pkg::LEN_64);
    inc[1]   = no_retry && (len > edts_pkg::LEN_64) && (len <= edts_pkg::LEN_127);
    inc[2]   = no_retry && (len > edts_pkg::LEN_127) && (len <= edts_pkg::LEN_255);
    inc[3]   = no_retry && (len > edts_pkg::LEN_255) && (len <= edts_pkg::LEN_511);
    inc[4]   = no_retry && (len > edts_pkg::LEN_511) && (len <= edts_pkg::LEN_1023);
    inc[5]   = no_retry && (len > edts_pkg::LEN_1023);
    // broadcast wins over multicast since a broadcast address is also group
    inc[8]   = good && status.broadcast;
    inc[7]   = good && status.multicast && !status.broadcast;
    inc[6]   = good && !status.multicast && !status.broadcast;
    inc[9]   = status.underrun;
    inc[10]  = status.aborted || status.heartbeat_fail;
    inc[11]  = status.retry && (status.coll_count == 4'h1);
    inc[12]  = status.retry && (status.coll_count > 4'h1);
    inc[13]  = status.deferred;
    inc[14]  = status.late_coll;
    inc[15]  = status.aborted;
    inc[16]  = status.no_carrier || status.loss_carrier;
    inc[17]  = status.excess_deferral;
  end
endmodule
`default_nettype wire

// ===== edts_soft_reset.sv
`timescale 1ns/1ns
`default_nettype none
module edts_soft_reset (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // control
  input  wire logic dma_soft_reset_bit,
  input  wire logic ahb_busy,
  output logic      reset_active
);
  typedef enum logic [1:0] {
    SR_RUN   = 2'b00,
    SR_DRAIN = 2'b01,
    SR_HELD  = 2'b11
  } edts_sr_state_t;

  typedef struct packed {
    edts_sr_state_t st;
  } edts_sr_t;

  edts_sr_t r;
  edts_sr_t next_r;

  always_comb begin
    next_r = r;
    case (r.st)
      SR_RUN: begin
        if (dma_soft_reset_bit) begin
          next_r.st = ahb_busy ? SR_DRAIN : SR_HELD;
        end
      end
      SR_DRAIN: begin
        if (!dma_soft_reset_bit) begin
          next_r.st = SR_RUN;
        end else if (!ahb_busy) begin
          next_r.st = SR_HELD;
        end
      end
      SR_HELD: begin
        if (!dma_soft_reset_bit) begin
          next_r.st = SR_RUN;
        end
      end
      default: next_r.st = SR_HELD;
    endcase
  end

  // comes up held after a hardware reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r.st <= SR_HELD;
    end else begin
      r <= next_r;
    end
  end

  assign reset_active = (r.st == SR_HELD);

  chk_drain_waits_ahb: assert property (@(posedge pclk) disable iff (!presetn)
    (!reset_active && ahb_busy) |=> !reset_active)
    else $error("soft reset applied while ahb master still busy");
endmodule
`default_nettype wire

// ===== edts_mac_model.sv
`timescale 1ns/1ns
`default_nettype none
module edts_mac_model (
  // clock and reset
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  // request from the bench
  input  wire logic                      send,
  input  wire edts_pkg::edts_tx_status_t send_status,
  // status report into the block
  output logic                           tx_status_valid,
  output edts_pkg::edts_tx_status_t      tx_status
);
  // ----------
  // report driver
  // ----------
  // idle word flips each cycle so a stale word never passes for a report
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_status_valid <= 1'b0;
      tx_status       <= '0;
    end else begin
      tx_status_valid <= send;
      tx_status       <= send ? send_status : ~tx_status;
    end
  end
endmodule
`default_nettype wire

// ===== test_eth_dma_ctrl_tx_stats.sv
`timescale 1ns/1ns
`default_nettype none
module test_eth_dma_ctrl_tx_stats;
  logic                      pclk = 1'b0;
  logic                      presetn = 1'b0;
  logic                      psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0]               paddr = '0, pwdata = '0, prdata, rd, d, prev;
  logic                      pready, pslverr, err, send = 1'b0, tx_status_valid;
  edts_pkg::edts_tx_status_t send_status = '0, tx_status, s;
  logic                      ahb_busy = 1'b0, tx_desc = 1'b0, rx_desc = 1'b0;
  logic [2:0]                tx_hburst, rx_hburst;
  logic                      dma_reset_active, loop_back, tx_fifo_pop;
  edts_pkg::edts_word_t      tx_fifo_word = '0, mac_rx_word = '0, rx_fifo_word;
  int                        n_fail = 0, compares = 0, cyc = 0;
  int unsigned               cnt [edts_pkg::CNT_NUM];
  logic [13:0]               lens [12] = '{63, 64, 65, 127, 128, 255, 256, 511, 512,
                                           1023, 1024, 1518};

  edts_dma_stats dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tx_status_valid(tx_status_valid),
    .tx_status(tx_status), .ahb_busy(ahb_busy), .tx_desc_phase(tx_desc),
    .rx_desc_phase(rx_desc), .tx_hburst(tx_hburst), .rx_hburst(rx_hburst),
    .dma_reset_active(dma_reset_active), .loop_back(loop_back), .tx_fifo_word(tx_fifo_word),
    .tx_fifo_pop(tx_fifo_pop), .mac_rx_word(mac_rx_word), .rx_fifo_word(rx_fifo_word));
  edts_mac_model mac_u (.pclk(pclk), .presetn(presetn), .send(send),
    .send_status(send_status), .tx_status_valid(tx_status_valid), .tx_status(tx_status));

  // ----------
  // clock, timeout, helpers
  // ----------
  always #50 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("counts compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  // entered right after a rising edge; leaves one idle edge behind it
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  function automatic logic [2:0] hb(input logic [1:0] c);
    return c == 2'h0 ? edts_pkg::HBURST_INCR16 : c == 2'h1 ? edts_pkg::HBURST_INCR8 :
           c == 2'h2 ? edts_pkg::HBURST_INCR4 : edts_pkg::HBURST_SINGLE;
  endfunction
  // reference counters, written straight from the counting conditions
  function automatic void model(input edts_pkg::edts_tx_status_t f);
    int  bin;
    logic good;
    good = !f.aborted && !f.retry;
    bin = f.frame_len == 64 ? 0 : f.frame_len < 65 ? -1 : f.frame_len < 128 ? 1 :
          f.frame_len < 256 ? 2 : f.frame_len < 512 ? 3 : f.frame_len < 1024 ? 4 : 5;
    if (!f.retry && bin >= 0) cnt[bin]++;
    cnt[6] += good && !f.multicast && !f.broadcast;
    cnt[7] += good && f.multicast && !f.broadcast;
    cnt[8] += good && f.broadcast;
    cnt[9] += f.underrun;
    cnt[10] += f.aborted | f.heartbeat_fail;
    cnt[11] += f.coll_count == 1 && f.retry;
    cnt[12] += f.coll_count > 1 && f.retry;
    cnt[13] += f.deferred;
    cnt[14] += f.late_coll;
    cnt[15] += f.aborted;
    cnt[16] += f.no_carrier | f.loss_carrier;
    cnt[17] += f.excess_deferral;
  endfunction
  task automatic read_counters();
    for (int i = 0; i < edts_pkg::CNT_NUM; i++) begin
      apb(1'b0, edts_pkg::CNT_ADDR[i], '0);
      chk($sformatf("counter %0d", i), cnt[i], rd);
      chk("mapped err", 0, 32'(err));
    end
  endtask

  // ----------
  // main sequence
  // ----------
  initial begin
    void'($urandom(73));
    cnt = '{default: 0};
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, edts_pkg::ADDR_STS_CNTL, '0);
    chk("control", {16'h4A4A, edts_pkg::REVISION_ARB, 8'h01}, rd);
    chk("held", 1, 32'(dma_reset_active));
    apb(1'b1, edts_pkg::ADDR_STS_CNTL, '0);
    repeat (3) @(posedge pclk);
    chk("released", 0, 32'(dma_reset_active));
    $display("test reset done");
    for (int n = 0; n < 300; n++) begin
      s = edts_pkg::edts_tx_status_t'(31'($urandom));
      s.frame_len = lens[$urandom_range(11)];
      s.coll_count = 4'($urandom_range(3));
      send <= 1'($urandom);
      send_status <= s;
      @(posedge pclk);
      if (send) model(s);
    end
    send <= 1'b0;
    repeat (3) @(posedge pclk);
    read_counters();
    apb(1'b1, edts_pkg::CNT_ADDR[0], 32'hFFFF_FFFF);
    apb(1'b0, edts_pkg::CNT_ADDR[0], '0);
    chk("counter write", cnt[0], rd);
    apb(1'b0, 32'h3000_3758, '0);
    chk("unmapped err", 1, 32'(err));
    chk("unmapped data", 0, rd);
    $display("test counters done");
    for (int i = 0; i < 16; i++) begin
      apb(1'b1, edts_pkg::ADDR_STS_CNTL, 32'(i << 4));
      @(negedge pclk);
      chk("tx burst", 32'(hb(2'(i >> 2))), 32'(tx_hburst));
      chk("rx burst", 32'(hb(2'(i))), 32'(rx_hburst));
      @(posedge pclk);
      apb(1'b0, edts_pkg::ADDR_STS_CNTL, '0);
      chk("burst field", {16'h4A4A, edts_pkg::REVISION_ARB, 8'(i << 4)}, rd);
    end
    tx_desc <= 1'b1;
    rx_desc <= 1'b1;
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    chk("tx desc", 32'(edts_pkg::HBURST_INCR4), 32'(tx_hburst));
    chk("rx desc", 32'(edts_pkg::HBURST_INCR4), 32'(rx_hburst));
    @(posedge pclk);
    tx_desc <= 1'b0;
    rx_desc <= 1'b0;
    $display("test burst done");
    apb(1'b1, edts_pkg::ADDR_STS_CNTL, 32'h02);
    repeat (2) @(posedge pclk);
    chk("loop flag", 1, 32'(loop_back));
    for (int i = 0; i < 9; i++) begin
      d = $urandom;
      tx_fifo_word <= '{data: d, valid: i < 8};
      mac_rx_word <= '{data: ~d, valid: 1'b1};
      @(negedge pclk);
      if (i > 0) chk("loop data", prev, rx_fifo_word.data);
      chk("pop", 32'(i < 8), 32'(tx_fifo_pop));
      prev = d;
      @(posedge pclk);
    end
    apb(1'b1, edts_pkg::ADDR_STS_CNTL, '0);
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    chk("mac feed", ~d, rx_fifo_word.data);
    chk("loop off", 0, 32'(loop_back));
    @(posedge pclk);
    $display("test loop back done");
    ahb_busy <= 1'b1;
    apb(1'b1, edts_pkg::ADDR_STS_CNTL, 32'h01);
    repeat (4) @(posedge pclk);
    @(negedge pclk);
    chk("busy defer", 0, 32'(dma_reset_active));
    @(posedge pclk);
    ahb_busy <= 1'b0;
    repeat (3) @(posedge pclk);
    @(negedge pclk);
    chk("soft held", 1, 32'(dma_reset_active));
    @(posedge pclk);
    apb(1'b1, edts_pkg::ADDR_STS_CNTL, '0);
    repeat (3) @(posedge pclk);
    cnt = '{default: 0};
    read_counters();
    $display("test soft reset done");
    complete_run();
  end
endmodule
`default_nettype wire
